// >>> hw/bct_pkg.sv
// Constants, opcode patterns and types for the instruction timing block
//==================================================================
// Behaviour
// - External data moves: one byte, three cycles
// - Code byte reads: one byte, three cycles
// - Bank register moves with A 1, with direct or immediate 2; indirect moves 2
// - Pointer load immediate: three bytes, three cycles
// - Immediate or direct to direct: 3 bytes/cycles
// - Stack push and pop: two bytes, two cycles
// - Nibble exchange swaps low nibbles, 1 byte/2 cycles
// - Right rotates and nibble swap: one cycle
// - Carry ops 1 cycle; bit ops 2/2
// - Carry branch: two bytes, 2/3 cycles
// - Bit branch 3/4; test-clear clears set bit
// - Accumulator zero branch: two bytes, 2/3
// - Compare branch 3/4, indirect form 4/5
// - Decrement branch: register 2/3, direct 3/4
// - Short relative and indexed jump: three cycles
// - Page call/jump: 11-bit target, same page
// - Long call/jump: 16-bit target, 3 bytes/4
// - Relative offset signed, from next instruction
// - Register picks one of eight; pointer R0/R1
// - Direct below midpoint is RAM, else special
// - Unused opcode behaves exactly as no-op
// - Untaken branch is one cycle shorter
// - Status bits 3 and 4 select register bank
package bct_pkg;

  //==================================================================
  // Widths and fixed values
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int LEN_W = 2;
  localparam int CYC_W = 3;
  localparam int PAGE_W = 11;
  localparam int BANK_LO = 3;
  localparam int BANK_HI = 4;
  localparam int SEL_W = 3;
  localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DIRECT_SPECIAL_BASE = 8'h80;
  localparam logic [DATA_W-1:0] DEC_LAST = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  //==================================================================
  // Lengths and cycle counts
  localparam logic [LEN_W-1:0] LEN_1 = 2'h1, LEN_2 = 2'h2, LEN_3 = 2'h3;
  localparam logic [CYC_W-1:0] CYC_FAST = 3'h1, CYC_IND = 3'h2;
  localparam logic [CYC_W-1:0] CYC_DIR = 3'h2, CYC_DIR3 = 3'h3;
  localparam logic [CYC_W-1:0] CYC_XMEM = 3'h3, CYC_CODE = 3'h3;
  localparam logic [CYC_W-1:0] CYC_IMM16 = 3'h3, CYC_STACK = 3'h2;
  localparam logic [CYC_W-1:0] CYC_BITOP = 3'h2, CYC_BR_C = 3'h2;
  localparam logic [CYC_W-1:0] CYC_BR_BIT = 3'h3, CYC_BR_ACC = 3'h2;
  localparam logic [CYC_W-1:0] CYC_CMP = 3'h3, CYC_CMP_IND = 3'h4;
  localparam logic [CYC_W-1:0] CYC_DEC_BANK = 3'h2, CYC_DEC_DIR = 3'h3;
  localparam logic [CYC_W-1:0] CYC_JUMP = 3'h3, CYC_LONG = 3'h4;
  localparam logic [CYC_W-1:0] CYC_RETURN = 3'h5, CYC_TAKEN_EXTRA = 3'h1;
  localparam logic [CYC_W-1:0] CNT_MAX = 3'h7, CNT_FIRST = 3'h1;

  //==================================================================
  // Opcode patterns
  localparam logic [7:0] OP_NOP = 8'h00, OP_UNUSED = 8'ha5;
  localparam logic [7:0] OP_ROT_R = 8'h03, OP_ROT_RC = 8'h13;
  localparam logic [7:0] OP_NIB_SWAP = 8'hc4, OP_A_FROM_DIR = 8'he5;
  localparam logic [7:0] OP_A_IMM = 8'h74, OP_DIR_FROM_A = 8'hf5;
  localparam logic [7:0] OP_EXCH_DIR = 8'hc5, OP_DIR_DIR = 8'h85;
  localparam logic [7:0] OP_DIR_IMM = 8'h75, OP_PTR_IMM = 8'h90;
  localparam logic [7:0] OP_CODE_DP = 8'h93, OP_CODE_PC = 8'h83;
  localparam logic [7:0] OP_EXT_RD_DP = 8'he0, OP_EXT_WR_DP = 8'hf0;
  localparam logic [7:0] OP_PUSH = 8'hc0, OP_POP = 8'hd0;
  localparam logic [7:0] OP_C_CLR = 8'hc3, OP_C_SET = 8'hd3;
  localparam logic [7:0] OP_C_INV = 8'hb3, OP_B_CLR = 8'hc2;
  localparam logic [7:0] OP_B_SET = 8'hd2, OP_B_INV = 8'hb2;
  localparam logic [7:0] OP_C_AND = 8'h82, OP_C_ANDN = 8'hb0;
  localparam logic [7:0] OP_C_OR = 8'h72, OP_C_ORN = 8'ha0;
  localparam logic [7:0] OP_C_LOAD = 8'ha2, OP_C_STORE = 8'h92;
  localparam logic [7:0] OP_BR_CS = 8'h40, OP_BR_CC = 8'h50;
  localparam logic [7:0] OP_BR_BS = 8'h20, OP_BR_BC = 8'h30;
  localparam logic [7:0] OP_BR_BTC = 8'h10, OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_LONG_JMP = 8'h02, OP_SUB_RET = 8'h22;
  localparam logic [7:0] OP_INT_RET = 8'h32, OP_SHORT_JMP = 8'h80;
  localparam logic [7:0] OP_INDEX_JMP = 8'h73, OP_BR_AZ = 8'h60;
  localparam logic [7:0] OP_BR_ANZ = 8'h70, OP_CMP_DIR = 8'hb5;
  localparam logic [7:0] OP_CMP_IMM = 8'hb4, OP_DEC_DIR = 8'hd5;
  localparam logic [7:0] OP_PAGE_CALL = 8'b???1_0001;
  localparam logic [7:0] OP_PAGE_JMP = 8'b???0_0001;
  localparam logic [7:0] OP_A_FROM_BANK = 8'b1110_1???;
  localparam logic [7:0] OP_BANK_FROM_A = 8'b1111_1???;
  localparam logic [7:0] OP_EXCH_BANK = 8'b1100_1???;
  localparam logic [7:0] OP_BANK_FROM_DIR = 8'b1010_1???;
  localparam logic [7:0] OP_DIR_FROM_BANK = 8'b1000_1???;
  localparam logic [7:0] OP_BANK_IMM = 8'b0111_1???;
  localparam logic [7:0] OP_CMP_BANK = 8'b1011_1???;
  localparam logic [7:0] OP_DEC_BANK = 8'b1101_1???;
  localparam logic [7:0] OP_A_FROM_IND = 8'b1110_011?;
  localparam logic [7:0] OP_IND_FROM_A = 8'b1111_011?;
  localparam logic [7:0] OP_EXCH_IND = 8'b1100_011?;
  localparam logic [7:0] OP_NIB_EXCH = 8'b1101_011?;
  localparam logic [7:0] OP_DIR_FROM_IND = 8'b1000_011?;
  localparam logic [7:0] OP_IND_FROM_DIR = 8'b1010_011?;
  localparam logic [7:0] OP_IND_IMM = 8'b0111_011?;
  localparam logic [7:0] OP_CMP_IND = 8'b1011_011?;
  localparam logic [7:0] OP_EXT_RD_PTR = 8'b1110_001?;
  localparam logic [7:0] OP_EXT_WR_PTR = 8'b1111_001?;

  //==================================================================
  // Types
  typedef enum logic [3:0] {
    CND_NONE, CND_CARRY_SET, CND_CARRY_CLR, CND_BIT_SET, CND_BIT_CLR,
    CND_BIT_TCLR, CND_ACC_ZERO, CND_ACC_NZ, CND_CMP_NE, CND_DEC_NZ
  } bct_cond_type;
  typedef enum logic [2:0] {
    JMP_NONE, JMP_REL, JMP_PAGE, JMP_FULL, JMP_INDEX, JMP_STACK
  } bct_jump_type;
  typedef enum logic [2:0] {
    DM_NONE, DM_CODE_DP, DM_CODE_PC, DM_EXT_DP
  } bct_dmode_type;
  typedef struct packed {
    logic             known;
    logic [LEN_W-1:0] len;
    logic [CYC_W-1:0] cyc_nt;
    logic [CYC_W-1:0] cyc_tk;
    bct_cond_type     cond;
    bct_jump_type     jump;
    bct_dmode_type    dmode;
    logic             call;
    logic             has_direct;
    logic             bank_op;
    logic             ind_op;
    logic             nib_exch;
  } bct_dec_type;
endpackage

// >>> hw/bct_dec_if.sv
// Opcode to decode-result carrier between sequencer and decoder
interface bct_dec_if;
  import bct_pkg::*;
  logic [7:0]  opcode;
  bct_dec_type dec;
  modport decoder (input opcode, output dec);
  modport user    (output opcode, input dec);
endinterface

// >>> hw/bct_decode.sv
// Opcode decoder: length, cycle counts and operand kinds
module bct_decode (
  bct_dec_if.decoder dif
);
  import bct_pkg::*;

  //==================================================================
  // Opcode table
  always_comb begin
    bct_dec_type d;
    d = '0;
    d.known = 1'b1;
    d.len = LEN_1;
    d.cyc_nt = CYC_FAST;
    d.cond = CND_NONE;
    d.jump = JMP_NONE;
    d.dmode = DM_NONE;
    unique casez (dif.opcode)
      OP_NOP, OP_UNUSED: d.cyc_nt = CYC_FAST;
      OP_ROT_R, OP_ROT_RC, OP_NIB_SWAP: d.cyc_nt = CYC_FAST;
      OP_C_CLR, OP_C_SET, OP_C_INV: d.cyc_nt = CYC_FAST;
      OP_A_FROM_BANK, OP_BANK_FROM_A, OP_EXCH_BANK: begin
        d.bank_op = 1'b1;
      end
      OP_A_FROM_IND, OP_IND_FROM_A, OP_EXCH_IND: begin
        d.cyc_nt = CYC_IND;
        d.ind_op = 1'b1;
      end
      OP_NIB_EXCH: begin
        d.cyc_nt = CYC_IND;
        d.ind_op = 1'b1;
        d.nib_exch = 1'b1;
      end
      OP_A_FROM_DIR, OP_DIR_FROM_A, OP_EXCH_DIR, OP_PUSH, OP_POP: begin
        d.len = LEN_2;
        d.cyc_nt = CYC_STACK;
        d.has_direct = 1'b1;
      end
      OP_A_IMM: begin
        d.len = LEN_2;
        d.cyc_nt = CYC_DIR;
      end
      OP_BANK_FROM_DIR, OP_DIR_FROM_BANK, OP_BANK_IMM: begin
        d.len = LEN_2;
        d.cyc_nt = CYC_DIR;
        d.bank_op = 1'b1;
        d.has_direct = (dif.opcode[7:3] != OP_BANK_IMM[7:3]);
      end
      OP_DIR_FROM_IND, OP_IND_FROM_DIR, OP_IND_IMM: begin
        d.len = LEN_2;
        d.cyc_nt = CYC_DIR;
        d.ind_op = 1'b1;
        d.has_direct = (dif.opcode[6:4] != OP_IND_IMM[6:4]);
      end
      OP_DIR_DIR, OP_DIR_IMM: begin
        d.len = LEN_3;
        d.cyc_nt = CYC_DIR3;
        d.has_direct = 1'b1;
      end
      OP_PTR_IMM: begin
        d.len = LEN_3;
        d.cyc_nt = CYC_IMM16;
      end
      OP_CODE_DP: begin
        d.cyc_nt = CYC_CODE;
        d.dmode = DM_CODE_DP;
      end
      OP_CODE_PC: begin
        d.cyc_nt = CYC_CODE;
        d.dmode = DM_CODE_PC;
      end
      OP_EXT_RD_PTR, OP_EXT_WR_PTR: begin
        d.cyc_nt = CYC_XMEM;
        d.ind_op = 1'b1;
      end
      OP_EXT_RD_DP, OP_EXT_WR_DP: begin
        d.cyc_nt = CYC_XMEM;
        d.dmode = DM_EXT_DP;
      end
      OP_B_CLR, OP_B_SET, OP_B_INV, OP_C_AND, OP_C_ANDN, OP_C_OR,
      OP_C_ORN, OP_C_LOAD, OP_C_STORE: begin
        d.len = LEN_2;
        d.cyc_nt = CYC_BITOP;
      end
      OP_BR_CS, OP_BR_CC: begin
        d.len = LEN_2;
        d.cyc_nt = CYC_BR_C;
        d.jump = JMP_REL;
        d.cond = dif.opcode[4] ? CND_CARRY_CLR : CND_CARRY_SET;
      end
      OP_BR_BS, OP_BR_BC, OP_BR_BTC: begin
        d.len = LEN_3;
        d.cyc_nt = CYC_BR_BIT;
        d.jump = JMP_REL;
        d.cond = (dif.opcode == OP_BR_BS) ? CND_BIT_SET :
                 (dif.opcode == OP_BR_BC) ? CND_BIT_CLR : CND_BIT_TCLR;
      end
      OP_BR_AZ, OP_BR_ANZ: begin
        d.len = LEN_2;
        d.cyc_nt = CYC_BR_ACC;
        d.jump = JMP_REL;
        d.cond = dif.opcode[4] ? CND_ACC_NZ : CND_ACC_ZERO;
      end
      OP_CMP_DIR, OP_CMP_IMM, OP_CMP_BANK, OP_CMP_IND: begin
        d.len = LEN_3;
        d.cyc_nt = (dif.opcode[3:1] == OP_CMP_IND[3:1]) ?
                   CYC_CMP_IND : CYC_CMP;
        d.jump = JMP_REL;
        d.cond = CND_CMP_NE;
        d.has_direct = (dif.opcode == OP_CMP_DIR);
        d.bank_op = dif.opcode[3];
        d.ind_op = (dif.opcode[3:1] == OP_CMP_IND[3:1]);
      end
      OP_DEC_BANK: begin
        d.len = LEN_2;
        d.cyc_nt = CYC_DEC_BANK;
        d.jump = JMP_REL;
        d.cond = CND_DEC_NZ;
        d.bank_op = 1'b1;
      end
      OP_DEC_DIR: begin
        d.len = LEN_3;
        d.cyc_nt = CYC_DEC_DIR;
        d.jump = JMP_REL;
        d.cond = CND_DEC_NZ;
        d.has_direct = 1'b1;
      end
      OP_SHORT_JMP: begin
        d.len = LEN_2;
        d.cyc_nt = CYC_JUMP;
        d.jump = JMP_REL;
      end
      OP_INDEX_JMP: begin
        d.cyc_nt = CYC_JUMP;
        d.jump = JMP_INDEX;
      end
      OP_PAGE_CALL, OP_PAGE_JMP: begin
        d.len = LEN_2;
        d.cyc_nt = CYC_JUMP;
        d.jump = JMP_PAGE;
        d.call = dif.opcode[4];
      end
      OP_LONG_CALL, OP_LONG_JMP: begin
        d.len = LEN_3;
        d.cyc_nt = CYC_LONG;
        d.jump = JMP_FULL;
        d.call = dif.opcode[4];
      end
      OP_SUB_RET, OP_INT_RET: begin
        d.cyc_nt = CYC_RETURN;
        d.jump = JMP_STACK;
      end
      default: d.known = 1'b0;
    endcase
    d.cyc_tk = (d.cond == CND_NONE) ? d.cyc_nt :
               d.cyc_nt + CYC_TAKEN_EXTRA;
    dif.dec = d;
  end

endmodule

// >>> hw/bct_core_timing.sv
// Fetch sequencer: collects instruction bytes and paces execution
module bct_core_timing (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      code_valid,
  input  wire logic [bct_pkg::DATA_W-1:0] code_byte,
  input  wire logic [bct_pkg::DATA_W-1:0] program_status_word,
  input  wire logic [bct_pkg::DATA_W-1:0] acc,
  input  wire logic [bct_pkg::ADDR_W-1:0] data_pointer_16,
  input  wire logic                      carry,
  input  wire logic                      bit_value,
  input  wire logic [bct_pkg::DATA_W-1:0] cmp_value,
  input  wire logic [bct_pkg::DATA_W-1:0] dec_value,
  input  wire logic [bct_pkg::DATA_W-1:0] ram_value,
  input  wire logic [bct_pkg::ADDR_W-1:0] stack_target,
  output logic                           code_ready,
  output logic                           instr_done,
  output logic                           instr_known,
  output logic [bct_pkg::LEN_W-1:0]      instr_len,
  output logic [bct_pkg::CYC_W-1:0]      instr_cycles,
  output logic                           branch_taken,
  output logic [bct_pkg::ADDR_W-1:0]     next_pc,
  output logic [bct_pkg::ADDR_W-1:0]     link_addr,
  output logic                           call_push,
  output logic [bct_pkg::DATA_W-1:0]     bank_addr,
  output logic [bct_pkg::DATA_W-1:0]     ind_addr,
  output logic                           direct_is_special,
  output logic                           bit_clear,
  output logic [bct_pkg::ADDR_W-1:0]     data_addr,
  output logic [bct_pkg::DATA_W-1:0]     exch_acc,
  output logic [bct_pkg::DATA_W-1:0]     exch_ram
);
  import bct_pkg::*;

  //==================================================================
  // State
  typedef enum logic [1:0] {ST_FETCH, ST_OPER, ST_EXEC} bct_st_type;

  typedef struct packed {
    bct_st_type        st;
    logic [7:0]        opcode;
    logic [DATA_W-1:0] op1;
    logic [LEN_W-1:0]  left;
    logic [CYC_W-1:0]  cnt;
    logic [CYC_W-1:0]  req;
    logic [ADDR_W-1:0] pc;
    logic              code_ready;
    logic              done;
    logic              known;
    logic [LEN_W-1:0]  len;
    logic [CYC_W-1:0]  cycles;
    logic              taken;
    logic [ADDR_W-1:0] next_pc;
    logic [ADDR_W-1:0] link;
    logic              call;
    logic [DATA_W-1:0] bank;
    logic [DATA_W-1:0] ind;
    logic              special;
    logic              bit_clear;
    logic [ADDR_W-1:0] daddr;
    logic [DATA_W-1:0] xacc;
    logic [DATA_W-1:0] xram;
  } bct_state_type;

  bct_state_type s_q;
  bct_state_type s_d;

  //==================================================================
  // Decoder
  bct_dec_if dif ();

  assign dif.opcode = (s_q.st == ST_FETCH) ? code_byte : s_q.opcode;

  bct_decode u_decode (
    .dif (dif)
  );

  //==================================================================
  // Next state
  always_comb begin
    bct_state_type     n;
    bct_dec_type       d;
    logic              fin;
    logic              cmpl;
    logic              tk;
    logic [DATA_W-1:0] last;
    logic [DATA_W-1:0] op1;
    logic [ADDR_W-1:0] pc_after;
    logic [ADDR_W-1:0] target;
    logic [1:0]        bank_sel;
    n = s_q;
    d = dif.dec;
    fin = 1'b0;
    cmpl = 1'b0;
    tk = 1'b0;
    last = code_byte;
    op1 = (d.len == LEN_3) ? s_q.op1 : code_byte;
    pc_after = s_q.pc + {{(ADDR_W-LEN_W){1'b0}}, d.len};
    target = pc_after;
    bank_sel = program_status_word[BANK_HI:BANK_LO];
    n.done = 1'b0;
    n.call = 1'b0;
    n.bit_clear = 1'b0;

    unique case (s_q.st)
      ST_FETCH: begin
        if (code_valid) begin
          n.opcode = code_byte;
          n.cnt = CNT_FIRST;
          n.left = d.len - LEN_1;
          if (d.len == LEN_1) begin
            fin = 1'b1;
          end else begin
            n.st = ST_OPER;
          end
        end
      end
      ST_OPER: begin
        n.cnt = (s_q.cnt == CNT_MAX) ? s_q.cnt : s_q.cnt + 3'h1;
        if (code_valid) begin
          n.left = s_q.left - LEN_1;
          if (s_q.left == LEN_2) begin
            n.op1 = code_byte;
          end
          if (s_q.left == LEN_1) begin
            fin = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        n.cnt = (s_q.cnt == CNT_MAX) ? s_q.cnt : s_q.cnt + 3'h1;
        if (n.cnt >= s_q.req) begin
          cmpl = 1'b1;
        end
      end
    endcase

    if (fin) begin
      unique case (d.cond)
        CND_NONE:      tk = 1'b1;
        CND_CARRY_SET: tk = carry;
        CND_CARRY_CLR: tk = !carry;
        CND_BIT_SET:   tk = bit_value;
        CND_BIT_TCLR:  tk = bit_value;
        CND_BIT_CLR:   tk = !bit_value;
        CND_ACC_ZERO:  tk = (acc == ZERO_BYTE);
        CND_ACC_NZ:    tk = (acc != ZERO_BYTE);
        CND_CMP_NE: begin
          tk = d.has_direct ? (acc != cmp_value) :
               (cmp_value != op1);
        end
        CND_DEC_NZ:    tk = (dec_value != DEC_LAST);
      endcase
      unique case (d.jump)
        JMP_NONE:  target = pc_after;
        JMP_REL: begin
          target = pc_after +
                   {{(ADDR_W-DATA_W){last[DATA_W-1]}}, last};
        end
        JMP_PAGE: begin
          target = {pc_after[ADDR_W-1:PAGE_W], s_q.opcode[7:5],
                    last};
        end
        JMP_FULL:  target = {op1, last};
        JMP_INDEX: begin
          target = data_pointer_16 +
                   {{(ADDR_W-DATA_W){1'b0}}, acc};
        end
        JMP_STACK: target = stack_target;
        default:   target = pc_after;
      endcase
      n.taken = tk && (d.jump != JMP_NONE);
      n.next_pc = (tk && (d.jump != JMP_NONE)) ? target : pc_after;
      n.req = tk ? d.cyc_tk : d.cyc_nt;
      n.cycles = n.req;
      n.len = d.len;
      n.known = d.known;
      n.link = pc_after;
      n.call = d.call;
      n.bank = d.bank_op ?
               {3'h0, bank_sel, dif.opcode[SEL_W-1:0]} : ZERO_BYTE;
      n.ind = d.ind_op ?
              {3'h0, bank_sel, 2'h0, dif.opcode[0]} : ZERO_BYTE;
      n.special = d.has_direct &&
                  (op1 >= DIRECT_SPECIAL_BASE);
      n.bit_clear = (d.cond == CND_BIT_TCLR) && bit_value;
      unique case (d.dmode)
        DM_CODE_DP: begin
          n.daddr = data_pointer_16 +
                    {{(ADDR_W-DATA_W){1'b0}}, acc};
        end
        DM_CODE_PC: begin
          n.daddr = pc_after +
                    {{(ADDR_W-DATA_W){1'b0}}, acc};
        end
        DM_EXT_DP:  n.daddr = data_pointer_16;
        default:    n.daddr = {ADDR_W{1'b0}};
      endcase
      if (d.nib_exch) begin
        n.xacc = {acc[7:4], ram_value[3:0]};
        n.xram = {ram_value[7:4], acc[3:0]};
      end
      if (n.cnt >= n.req) begin
        cmpl = 1'b1;
      end else begin
        n.st = ST_EXEC;
      end
    end

    if (cmpl) begin
      n.st = ST_FETCH;
      n.done = 1'b1;
      n.pc = n.next_pc;
    end
    n.code_ready = (n.st != ST_EXEC);
    s_d = n;
  end

  //==================================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= ST_FETCH;
      s_q.pc <= PC_RESET;
      s_q.next_pc <= PC_RESET;
      s_q.code_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  //==================================================================
  // Outputs
  assign code_ready = s_q.code_ready;
  assign instr_done = s_q.done;
  assign instr_known = s_q.known;
  assign instr_len = s_q.len;
  assign instr_cycles = s_q.cycles;
  assign branch_taken = s_q.taken;
  assign next_pc = s_q.next_pc;
  assign link_addr = s_q.link;
  assign call_push = s_q.call;
  assign bank_addr = s_q.bank;
  assign ind_addr = s_q.ind;
  assign direct_is_special = s_q.special;
  assign bit_clear = s_q.bit_clear;
  assign data_addr = s_q.daddr;
  assign exch_acc = s_q.xacc;
  assign exch_ram = s_q.xram;

endmodule

// >>> testbench/bct_prog_mem.sv
// Program memory model feeding the fetch port in program order
module bct_prog_mem (
  input  wire logic       clk_sys,
  input  wire logic       stall,
  input  wire logic       code_ready,
  output logic            code_valid,
  output logic [7:0]      code_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;
  int         rp = 0;
  int         wp = 0;
  //==================================================================
  // Fetch side
  // Bytes offered only when queued and not held back
  assign code_valid = (rp < wp) && !stall;
  // A released bus shows the inverse of the last byte
  assign code_byte = code_valid ? mem[rp[7:0]] : ~last_q;
  always @(posedge clk_sys) begin
    if (code_valid && code_ready) begin
      last_q <= code_byte;
      rp <= rp + 1;
    end
  end
endmodule

// >>> testbench/bct_core_timing_monitor.sv
// Port assertions for the instruction timing block
module bct_core_timing_monitor
  import bct_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              code_valid,
  input wire logic [DATA_W-1:0] code_byte,
  input wire logic [DATA_W-1:0] program_status_word,
  input wire logic [DATA_W-1:0] acc,
  input wire logic [DATA_W-1:0] ram_value,
  input wire logic              code_ready,
  input wire logic              instr_done,
  input wire logic [LEN_W-1:0]  instr_len,
  input wire logic [CYC_W-1:0]  instr_cycles,
  input wire logic [ADDR_W-1:0] next_pc,
  input wire logic [DATA_W-1:0] bank_addr,
  input wire logic [DATA_W-1:0] ind_addr,
  input wire logic              bit_clear,
  input wire logic [DATA_W-1:0] exch_acc
);
  logic       idle_q;
  logic       at_op;
  logic [1:0] bank;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  //==================================================================
  // Opcode edge tracking
  assign bank = program_status_word[4:3];
  assign at_op = code_ready && code_valid && (idle_q || instr_done);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) idle_q <= 1'b1;
    else if (at_op) idle_q <= 1'b0;
    else if (instr_done) idle_q <= 1'b1;
  end
  sequence s_exec_wait;
    !code_ready [*2];
  endsequence
  sequence s_done_len1;
    instr_done && instr_len == 2'h1;
  endsequence
  //==================================================================
  // Assertions
  a_nop_single: assert property (
    at_op && code_byte inside {8'h00, 8'ha5} |=> s_done_len1 and
    (instr_cycles == 3'h1 && next_pc == $past(next_pc) + 16'h1))
    else $error("no-op timing wrong");
  a_rotate_single: assert property (
    at_op && code_byte inside {8'h03, 8'h13, 8'hc4} |=> s_done_len1)
    else $error("rotate timing wrong");
  a_xdata_three: assert property (
    at_op && code_byte inside {8'he0, 8'hf0, 8'he2, 8'he3, 8'hf2, 8'hf3}
    |=> s_exec_wait ##1 (instr_done && instr_cycles == 3'h3))
    else $error("external move timing wrong");
  a_code_three: assert property (
    at_op && code_byte inside {8'h93, 8'h83}
    |=> s_exec_wait ##1 s_done_len1)
    else $error("code read timing wrong");
  a_bank_move: assert property (
    at_op && code_byte[7:3] == 5'h1d |=> s_done_len1 and
    (bank_addr == {3'h0, $past(bank), $past(code_byte[2:0])}))
    else $error("bank register move wrong");
  a_ind_move: assert property (
    at_op && code_byte[7:1] == 7'h73 |=> !instr_done ##1 (instr_done
    && ind_addr == {3'h0, $past(bank, 2), 2'h0, $past(code_byte[0], 2)}))
    else $error("indirect move wrong");
  a_nibble_exch: assert property (
    at_op && code_byte[7:1] == 7'h6b |=> ##1 instr_done && exch_acc ==
    (($past(acc, 2) & 8'hf0) | ($past(ram_value, 2) & 8'h0f)))
    else $error("nibble exchange wrong");
  a_done_ready: assert property (
    instr_done |-> code_ready && instr_len != 2'h0
    && instr_cycles >= {1'b0, instr_len})
    else $error("completion figures wrong");
  a_clear_pulse: assert property (
    bit_clear |=> !bit_clear)
    else $error("bit clear not a pulse");
endmodule
bind bct_core_timing bct_core_timing_monitor mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .code_valid(code_valid),
  .code_byte(code_byte), .program_status_word(program_status_word),
  .acc(acc), .ram_value(ram_value), .code_ready(code_ready),
  .instr_done(instr_done), .instr_len(instr_len),
  .instr_cycles(instr_cycles), .next_pc(next_pc), .bank_addr(bank_addr),
  .ind_addr(ind_addr), .bit_clear(bit_clear), .exch_acc(exch_acc)
);

// >>> testbench/test_byte_cpu_instruction_timing.sv
// Self-checking bench for the instruction timing block
module test_byte_cpu_instruction_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst_n = 1'b0, carry = 1'b0, bit_value = 1'b0;
  logic stall = 1'b0, code_valid, code_ready, instr_done, instr_known;
  logic branch_taken, call_push, direct_is_special, bit_clear, cp, bc;
  logic [7:0] code_byte, program_status_word = 8'h00, acc = 8'h00;
  logic [7:0] cmp_value = 8'h00, dec_value = 8'h00, ram_value = 8'h00;
  logic [7:0] bank_addr, ind_addr, exch_acc, exch_ram;
  logic [15:0] data_pointer_16 = 16'h0000, stack_target = 16'h0000;
  logic [15:0] next_pc, link_addr, data_addr, pc = 16'h0000;
  logic [1:0] instr_len;
  logic [2:0] instr_cycles;
  int n_fail = 0, compares = 0, gap = 0;
  always #12.5 clk_sys = ~clk_sys;
  bct_prog_mem pm (.clk_sys, .stall, .code_ready, .code_valid, .code_byte);
  bct_core_timing uut (.clk_sys, .rst_n, .code_valid, .code_byte,
    .program_status_word, .acc, .data_pointer_16, .carry, .bit_value,
    .cmp_value, .dec_value, .ram_value, .stack_target, .code_ready,
    .instr_done, .instr_known, .instr_len, .instr_cycles, .branch_taken,
    .next_pc, .link_addr, .call_push, .bank_addr, .ind_addr,
    .direct_is_special, .bit_clear, .data_addr, .exch_acc, .exch_ram);
  //==================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ex(input logic [7:0] b0, b1, b2, input int n, c,
                    input logic tk, input logic [15:0] tgt);
    int k;
    pm.mem[pm.wp] = b0;
    pm.mem[pm.wp + 1] = b1;
    pm.mem[pm.wp + 2] = b2;
    pm.wp += n;
    k = 0;
    cp = 1'b0;
    bc = 1'b0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
      if (k == gap) stall <= 1'b0;
      cp |= call_push;
      bc |= bit_clear;
    end while (instr_done !== 1'b1 && k < 40);
    chk(k, c + gap);
    chk(instr_cycles, c);
    chk(instr_len, n);
    chk(instr_known, 1'b1);
    chk(branch_taken, tk);
    chk(next_pc, tgt);
    pc = tgt;
  endtask
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  //==================================================================
  // Scenarios
  task automatic t_plain;
    logic [15:0] t [22] = '{16'h0011, 16'ha511, 16'h0311, 16'h1311,
      16'hc411, 16'he811, 16'he612, 16'he013, 16'hf013, 16'he213, 16'hf313,
      16'h9313, 16'h8313, 16'h9033, 16'h7533, 16'h8533, 16'hc022, 16'hd022,
      16'hd612, 16'hc311, 16'h8222, 16'h9222};
    foreach (t[i]) ex(t[i][15:8], 8'h10, 8'h20, t[i][7:4], t[i][3:0], 1'b0,
      pc + t[i][7:4]);
    $display("plain timing done");
  endtask
  task automatic t_branch;
    carry <= 1'b1;
    ex(8'h40, 8'hfe, 8'h00, 2, 3, 1'b1, pc);
    ex(8'h50, 8'h05, 8'h00, 2, 2, 1'b0, pc + 16'd2);
    bit_value <= 1'b1;
    ex(8'h10, 8'h2a, 8'h7f, 3, 4, 1'b1, pc + 16'd130);
    chk(bc, 1'b1);
    bit_value <= 1'b0;
    ex(8'h20, 8'h2a, 8'h04, 3, 3, 1'b0, pc + 16'd3);
    ex(8'h60, 8'h10, 8'h00, 2, 3, 1'b1, pc + 16'd18);
    ex(8'h70, 8'h10, 8'h00, 2, 2, 1'b0, pc + 16'd2);
    cmp_value <= 8'h33;
    ex(8'hb4, 8'h33, 8'h10, 3, 3, 1'b0, pc + 16'd3);
    ex(8'hb6, 8'h34, 8'h80, 3, 5, 1'b1, pc - 16'd125);
    dec_value <= 8'h01;
    ex(8'hd9, 8'h10, 8'h00, 2, 2, 1'b0, pc + 16'd2);
    dec_value <= 8'h05;
    ex(8'hd5, 8'h40, 8'hf0, 3, 4, 1'b1, pc - 16'd13);
    $display("branch timing done");
  endtask
  task automatic t_jump;
    logic [15:0] a;
    ex(8'h80, 8'h80, 8'h00, 2, 3, 1'b1, pc - 16'd126);
    acc <= 8'h05;
    data_pointer_16 <= 16'h1230;
    ex(8'h73, 8'h00, 8'h00, 1, 3, 1'b1, 16'h1235);
    ex(8'h93, 8'h00, 8'h00, 1, 3, 1'b0, pc + 16'd1);
    chk(data_addr, 16'h1235);
    a = pc + 16'd2;
    ex(8'hf1, 8'h5a, 8'h00, 2, 3, 1'b1, {a[15:11], 3'h7, 8'h5a});
    chk(cp, 1'b1);
    a = pc + 16'd3;
    ex(8'h12, 8'hbe, 8'hef, 3, 4, 1'b1, 16'hbeef);
    chk(link_addr, a);
    ex(8'h02, 8'h00, 8'h40, 3, 4, 1'b1, 16'h0040);
    $display("jump timing done");
  endtask
  task automatic t_addr;
    program_status_word <= 8'h10;
    gap = 2;
    stall <= 1'b1;
    ex(8'hed, 8'h00, 8'h00, 1, 1, 1'b0, pc + 16'd1);
    gap = 0;
    chk(bank_addr, 8'h15);
    ex(8'he7, 8'h00, 8'h00, 1, 2, 1'b0, pc + 16'd1);
    chk(ind_addr, 8'h11);
    ex(8'he5, 8'h80, 8'h00, 2, 2, 1'b0, pc + 16'd2);
    chk(direct_is_special, 1'b1);
    ex(8'he5, 8'h7f, 8'h00, 2, 2, 1'b0, pc + 16'd2);
    chk(direct_is_special, 1'b0);
    acc <= 8'h3c;
    ram_value <= 8'ha5;
    ex(8'hd6, 8'h00, 8'h00, 1, 2, 1'b0, pc + 16'd1);
    chk(exch_acc, 8'h35);
    chk(exch_ram, 8'hac);
    $display("addressing done");
  endtask
  //==================================================================
  // Sequence and watchdog
  initial begin
    #50us;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    t_plain;
    t_branch;
    t_jump;
    t_addr;
    test_done;
  end
endmodule
